// ---- src/afesc_regs.sv ----
// Serial control register bank with strobe-timed update buffer
`timescale 1ns/1ps
module afesc_regs #(
   parameter int ADC_BITS = 10
) (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        serial_clk,
   input  wire logic        serial_in,
   input  wire logic        serial_load_strobe,
   input  wire logic        update_strobe,
   output logic             update_buffered,
   output logic             dummy_clamp_pol_high,
   output logic             black_clamp_pol_high,
   output logic             sample_pol_high,
   output logic             standby_all,
   output logic             standby_aux1,
   output logic             standby_aux2,
   output logic             test_enable,
   output logic [2:0]       data_delay_ns,
   output logic             data_out_hiz,
   output logic [1:0]       level_delay_sel,
   output logic [4:0]       clamp_code,
   output logic [15:0]      clamp_target,
   output logic [5:0]       defect_reject_level,
   output logic [9:0]       digital_gain,
   output logic [3:0]       analog_gain,
   output logic [5:0]       power_trim,
   output logic [7:0]       aux1_code,
   output logic [7:0]       aux2_code
);
   localparam int DW = afesc_pkg::DATA_W;
   localparam int NR = afesc_pkg::NUM_REGS;

   // ---------------------------------------------------------------
   // Clamp level per variant
   // ---------------------------------------------------------------
   localparam logic [15:0] CL_BASE = (ADC_BITS == 16) ?
      afesc_pkg::CLAMP_BASE_16 : (ADC_BITS == 12) ?
      afesc_pkg::CLAMP_BASE_12 : afesc_pkg::CLAMP_BASE_10;
   localparam logic [15:0] CL_STEP = (ADC_BITS == 16) ?
      afesc_pkg::CLAMP_STEP_16 : (ADC_BITS == 12) ?
      afesc_pkg::CLAMP_STEP_12 : afesc_pkg::CLAMP_STEP_10;
   localparam logic [15:0] CL_DEF = (ADC_BITS == 16) ?
      afesc_pkg::CLAMP_DEF_16 : (ADC_BITS == 12) ?
      afesc_pkg::CLAMP_DEF_12 : afesc_pkg::CLAMP_DEF_10;

   // Base plus step per code; widest case 4992 fits 16 bits
   function automatic logic [15:0] clamp_level(input logic [4:0] code);
      logic [31:0] prod;
      prod        = CL_STEP * {27'h000_0000, code};
      clamp_level = CL_BASE + prod[15:0];
   endfunction

   // ---------------------------------------------------------------
   // Serial receiver
   // ---------------------------------------------------------------
   afesc_wr_if wr ();

   afesc_serial_rx u_rx (
      .sys_clk            (sys_clk),
      .srst               (srst),
      .serial_clk         (serial_clk),
      .serial_in          (serial_in),
      .serial_load_strobe (serial_load_strobe),
      .update_strobe      (update_strobe),
      .wr                 (wr.rx)
   );

   // ---------------------------------------------------------------
   // Register bank
   // ---------------------------------------------------------------
   logic [DW-1:0] act_ff [NR];
   logic [DW-1:0] nxt_act [NR];
   logic [DW-1:0] stg_ff [NR];
   logic [DW-1:0] nxt_stg [NR];
   logic [NR-1:0] pend_ff;
   logic [NR-1:0] nxt_pend;
   logic          wr_hit;
   logic [3:0]    wr_idx;
   logic [DW-1:0] wr_masked;
   logic          buffered;
   logic          upd_edge;

   // Out-of-range addresses are dropped, nothing is stored
   assign wr_hit    = wr.wr_valid &&
                      (wr.wr_addr < afesc_pkg::ADDR_LIMIT);
   assign wr_idx    = wr.wr_addr[3:0];
   assign wr_masked = wr.wr_data &
                      afesc_pkg::REG_MASK[wr_idx];

   // Edge bit alone is enough to select buffered updates
   assign buffered = act_ff[afesc_pkg::IDX_POL][afesc_pkg::POL_BUF_BIT] |
                     act_ff[afesc_pkg::IDX_POL][afesc_pkg::POL_FALL_BIT];
   assign upd_edge = act_ff[afesc_pkg::IDX_POL][afesc_pkg::POL_FALL_BIT]
                     ? wr.upd_fall : wr.upd_rise;

   // Strobe edge applies older staged words; a write in the same
   // cycle stays pending so it is not lost
   always_comb begin
      nxt_act  = act_ff;
      nxt_stg  = stg_ff;
      nxt_pend = pend_ff;
      if (buffered && upd_edge) begin
         for (int i = 0; i < NR; i++) begin
            if (pend_ff[i]) begin
               nxt_act[i] = stg_ff[i];
            end
         end
         nxt_pend = '0;
      end
      if (wr_hit) begin
         nxt_stg[wr_idx] = wr_masked;
         if (buffered) begin
            nxt_pend[wr_idx] = 1'b1;
         end else begin
            nxt_act[wr_idx] = wr_masked;
         end
      end
   end

   // Defaults on reset for live and staged copies
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < NR; i++) begin
            act_ff[i] <= afesc_pkg::REG_RST[i];
            stg_ff[i] <= afesc_pkg::REG_RST[i];
         end
         pend_ff <= '0;
      end else begin
         act_ff  <= nxt_act;
         stg_ff  <= nxt_stg;
         pend_ff <= nxt_pend;
      end
   end

   // ---------------------------------------------------------------
   // Derived clamp target
   // ---------------------------------------------------------------
   logic [15:0] clamp_target_ff;
   logic [15:0] nxt_clamp_target;

   // Registered so the target never glitches while code changes
   always_comb begin
      nxt_clamp_target =
         clamp_level(act_ff[afesc_pkg::IDX_CLAMP][4:0]);
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         clamp_target_ff <= CL_DEF;
      end else begin
         clamp_target_ff <= nxt_clamp_target;
      end
   end

   // ---------------------------------------------------------------
   // Field outputs straight from the live registers, clamp target registered
   // ---------------------------------------------------------------
   assign update_buffered      = buffered;
   assign dummy_clamp_pol_high =
      act_ff[afesc_pkg::IDX_POL][afesc_pkg::POL_DUMMY_BIT];
   assign black_clamp_pol_high =
      act_ff[afesc_pkg::IDX_POL][afesc_pkg::POL_BLACK_BIT];
   assign sample_pol_high      =
      act_ff[afesc_pkg::IDX_POL][afesc_pkg::POL_SAMP_BIT];
   assign standby_all          =
      act_ff[afesc_pkg::IDX_SBY][afesc_pkg::SBY_ALL_BIT];
   assign standby_aux1         =
      act_ff[afesc_pkg::IDX_SBY][afesc_pkg::SBY_AUX1_BIT];
   assign standby_aux2         =
      act_ff[afesc_pkg::IDX_SBY][afesc_pkg::SBY_AUX2_BIT];
   assign test_enable          =
      act_ff[afesc_pkg::IDX_SBY][afesc_pkg::SBY_TEST_BIT];
   // Code times step gives the delay in ns
   assign data_delay_ns = 3'(act_ff[afesc_pkg::IDX_OUT][1:0] *
                             afesc_pkg::DELAY_STEP_NS);
   assign data_out_hiz         =
      act_ff[afesc_pkg::IDX_OUT][afesc_pkg::OUT_HIZ_BIT];
   // Codes 10 and 11 pass through unchecked; host must avoid them
   assign level_delay_sel = act_ff[afesc_pkg::IDX_SDLY][1:0];
   assign clamp_code      = act_ff[afesc_pkg::IDX_CLAMP][4:0];
   assign clamp_target    = clamp_target_ff;
   assign defect_reject_level = act_ff[afesc_pkg::IDX_DEFECT];
   assign digital_gain    = {act_ff[afesc_pkg::IDX_DG_HI][3:0],
                             act_ff[afesc_pkg::IDX_DG_LO]};
   assign analog_gain     = act_ff[afesc_pkg::IDX_AGAIN][3:0];
   assign power_trim      = act_ff[afesc_pkg::IDX_POWER];
   assign aux1_code       = {act_ff[afesc_pkg::IDX_AUX1_H][1:0],
                             act_ff[afesc_pkg::IDX_AUX1_L]};
   assign aux2_code       = {act_ff[afesc_pkg::IDX_AUX2_H][1:0],
                             act_ff[afesc_pkg::IDX_AUX2_L]};

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [DW-1:0]                act_at_wr;
   logic                         fz_ok;
   logic [afesc_pkg::ADDR_W-1:0] last_addr_ff;

   assign act_at_wr = act_ff[wr_idx];

   // Every live word must be clean of non-writable bits
   always_comb begin
      fz_ok = 1'b1;
      for (int i = 0; i < NR; i++) begin
         if ((act_ff[i] & ~afesc_pkg::REG_MASK[i]) != '0) begin
            fz_ok = 1'b0;
         end
      end
   end

   // Address of the previous write, for the step check
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         last_addr_ff <= '0;
      end else if (wr.wr_valid) begin
         last_addr_ff <= wr.wr_addr;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   sequence s_buf_write;
      buffered && wr_hit && !upd_edge;
   endsequence

   sequence s_rt_write;
      !buffered && wr_hit;
   endsequence

   a_realtime_write_lands: assert property (
      s_rt_write |=> act_ff[$past(wr_idx)] == $past(wr_masked))
      else $error("realtime write not applied next cycle");

   a_buffered_write_held: assert property (
      s_buf_write |=> act_ff[$past(wr_idx)] == $past(act_at_wr))
      else $error("buffered write reached live register early");

   a_d2_forces_buffer: assert property (
      (s_buf_write and act_ff[0][afesc_pkg::POL_FALL_BIT])
      |=> pend_ff[$past(wr_idx)])
      else $error("edge bit set but write not held");

   a_rise_ignored_fall: assert property (
      (act_ff[0][afesc_pkg::POL_FALL_BIT] && wr.upd_rise && !wr_hit)
      |=> pend_ff == $past(pend_ff))
      else $error("rising strobe applied in falling mode");

   a_fall_ignored_rise: assert property (
      (buffered && !act_ff[0][afesc_pkg::POL_FALL_BIT] &&
       wr.upd_fall && !wr_hit) |=> pend_ff == $past(pend_ff))
      else $error("falling strobe applied in rising mode");

   a_edge_clears_pend: assert property (
      (buffered && upd_edge && !wr_hit) |=> pend_ff == '0)
      else $error("update edge left words pending");

   a_fixed_zero_clean: assert property (
      fz_ok)
      else $error("fixed-zero bit set in live register");

   a_reset_defaults: assert property (
      $fell(srst) |-> act_ff[1] == afesc_pkg::REG_RST[1] &&
      act_ff[4] == afesc_pkg::REG_RST[4] && pend_ff == '0 &&
      act_ff[7] == afesc_pkg::REG_RST[7])
      else $error("register not at default after reset");

   a_clamp_default_lvl: assert property (
      (act_ff[afesc_pkg::IDX_CLAMP][4:0] == afesc_pkg::CLAMP_DEF_CODE)[*2]
      |-> clamp_target == CL_DEF)
      else $error("default clamp code gives wrong target");

   a_cont_addr_step: assert property (
      (wr.wr_valid && wr.wr_cont) |-> wr.wr_addr == last_addr_ff + 10'h001)
      else $error("continuous group not at next address");

   // Top clamp code as base plus a full span of steps less one
   localparam logic [15:0] CL_TOP =
      16'(CL_BASE + (CL_STEP << $bits(clamp_code)) - CL_STEP);

   // Staged standby word meets its update edge
   sequence s_upd_apply;
      buffered && upd_edge && pend_ff[afesc_pkg::IDX_SBY];
   endsequence

   a_edge_applies_stg: assert property (
      s_upd_apply |=> act_ff[afesc_pkg::IDX_SBY] ==
                      $past(stg_ff[afesc_pkg::IDX_SBY]))
      else $error("update edge did not apply staged word");

   a_live_word_holds: assert property (
      (!buffered && !wr_hit) |=> act_ff[afesc_pkg::IDX_SBY] ==
                                 $past(act_ff[afesc_pkg::IDX_SBY]))
      else $error("live register changed without a write");

   a_wr_single_pulse: assert property (
      wr.wr_valid |=> !wr.wr_valid)
      else $error("word strobe held for two cycles");

   a_clamp_top_lvl: assert property (
      (&clamp_code)[*2] |-> clamp_target == CL_TOP)
      else $error("top clamp code gives wrong target");

endmodule

// ---- common/afesc_pkg.sv ----
// Constants, register map and types of the serial control register bank
// Overview of operation
// - Command is 10 address bits, 6 data bits
// - Addresses 0x000 to 0x00D select fourteen registers
// - Update bit clear: immediate; set: wait strobe
// - Edge bit picks rising or falling strobe edge
// - Edge bit set forces strobe-timed updates
// - Bits 3-5 set clamp and sample polarities
// - Standby bit 0 stops whole device
// - Converter standby bits default one; test bit
// - Output delay codes give 0/2/4/6 ns
// - Bit 4 tri-states the data outputs
// - Sample delay codes give 0 or 2 ns
// - Clamp target 16 plus 2 per step
// - Wider variants: 64+8n and 1024+128n
// - Shift on clock rise, latch on load rise
// - Address then data, both LSB first
// - Extra six-bit groups go to next address
package afesc_pkg;

   // ---------------------------------------------------------------
   // Frame format
   // ---------------------------------------------------------------
   localparam int ADDR_W   = 10;
   localparam int DATA_W   = 6;
   localparam int NUM_REGS = 14;
   localparam int CNT_W    = 4;
   localparam logic [CNT_W-1:0]  ADDR_LAST  = 4'h9;
   localparam logic [CNT_W-1:0]  DATA_LAST  = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_LIMIT = 10'h00e;

   // ---------------------------------------------------------------
   // Register indices
   // ---------------------------------------------------------------
   localparam int IDX_POL    = 0;
   localparam int IDX_SBY    = 1;
   localparam int IDX_OUT    = 2;
   localparam int IDX_SDLY   = 3;
   localparam int IDX_CLAMP  = 4;
   localparam int IDX_DEFECT = 5;
   localparam int IDX_DG_LO  = 6;
   localparam int IDX_DG_HI  = 7;
   localparam int IDX_AGAIN  = 8;
   localparam int IDX_POWER  = 9;
   localparam int IDX_AUX1_L = 10;
   localparam int IDX_AUX1_H = 11;
   localparam int IDX_AUX2_L = 12;
   localparam int IDX_AUX2_H = 13;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int POL_BUF_BIT   = 1;
   localparam int POL_FALL_BIT  = 2;
   localparam int POL_DUMMY_BIT = 3;
   localparam int POL_BLACK_BIT = 4;
   localparam int POL_SAMP_BIT  = 5;
   localparam int SBY_ALL_BIT   = 0;
   localparam int SBY_AUX1_BIT  = 1;
   localparam int SBY_AUX2_BIT  = 2;
   localparam int SBY_TEST_BIT  = 3;
   localparam int OUT_HIZ_BIT   = 4;
   localparam int DELAY_STEP_NS = 2;

   // ---------------------------------------------------------------
   // Writable bits and reset values, index 13 leftmost
   // ---------------------------------------------------------------
   localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_MASK = {
      6'h07, 6'h3f, 6'h07, 6'h3f, 6'h3f, 6'h0f, 6'h1f,
      6'h3f, 6'h3f, 6'h3f, 6'h07, 6'h37, 6'h1f, 6'h3e};
   localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RST = {
      6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h03,
      6'h00, 6'h3f, 6'h08, 6'h00, 6'h00, 6'h06, 6'h00};

   // ---------------------------------------------------------------
   // Clamp level per variant
   // ---------------------------------------------------------------
   localparam logic [4:0]  CLAMP_DEF_CODE = 5'h08;
   localparam logic [15:0] CLAMP_BASE_10  = 16'h0010;
   localparam logic [15:0] CLAMP_STEP_10  = 16'h0002;
   localparam logic [15:0] CLAMP_DEF_10   = 16'h0020;
   localparam logic [15:0] CLAMP_BASE_12  = 16'h0040;
   localparam logic [15:0] CLAMP_STEP_12  = 16'h0008;
   localparam logic [15:0] CLAMP_DEF_12   = 16'h0080;
   localparam logic [15:0] CLAMP_BASE_16  = 16'h0400;
   localparam logic [15:0] CLAMP_STEP_16  = 16'h0080;
   localparam logic [15:0] CLAMP_DEF_16   = 16'h0800;

   typedef enum logic [1:0] {
      RX_ADDR = 2'b00,
      RX_DATA = 2'b01,
      RX_HOLD = 2'b11,
      RX_CONT = 2'b10
   } afesc_rx_state_e;

endpackage

// ---- common/afesc_wr_if.sv ----
// Write strobes from the serial receiver to the register bank
`timescale 1ns/1ps
interface afesc_wr_if;
   logic                          wr_valid;
   logic                          wr_cont;
   logic [afesc_pkg::ADDR_W-1:0]  wr_addr;
   logic [afesc_pkg::DATA_W-1:0]  wr_data;
   logic                          upd_rise;
   logic                          upd_fall;
   modport rx   (output wr_valid, wr_cont, wr_addr, wr_data,
                 upd_rise, upd_fall);
   modport bank (input  wr_valid, wr_cont, wr_addr, wr_data,
                 upd_rise, upd_fall);
endinterface

// ---- src/afesc_serial_rx.sv ----
// Three-wire serial receiver: pin sync, shifting, word strobes
`timescale 1ns/1ps
module afesc_serial_rx (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic serial_clk,
   input  wire logic serial_in,
   input  wire logic serial_load_strobe,
   input  wire logic update_strobe,
   afesc_wr_if.rx    wr
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [3:0] sync1_ff;
   logic [3:0] sync2_ff;
   logic [3:0] prev_ff;
   logic       sclk_rise;
   logic       load_lvl;
   logic       load_rise;
   logic       sdat;

   // Two stages per pin; edges only from the second stage
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
         prev_ff  <= 4'h0;
      end else begin
         sync1_ff <= {update_strobe, serial_load_strobe, serial_in,
                      serial_clk};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign sclk_rise   = sync2_ff[0] & ~prev_ff[0];
   assign sdat        = sync2_ff[1];
   assign load_lvl    = sync2_ff[2];
   assign load_rise   = sync2_ff[2] & ~prev_ff[2];
   assign wr.upd_rise = sync2_ff[3] & ~prev_ff[3];
   assign wr.upd_fall = ~sync2_ff[3] & prev_ff[3];

   // ---------------------------------------------------------------
   // Frame assembly
   // ---------------------------------------------------------------
   afesc_pkg::afesc_rx_state_e       state_ff, nxt_state;
   logic [afesc_pkg::CNT_W-1:0]      cnt_ff, nxt_cnt;
   logic [afesc_pkg::ADDR_W-1:0]     addr_ff, nxt_addr;
   logic [afesc_pkg::DATA_W-1:0]     data_ff, nxt_data;
   logic                             wv_ff, nxt_wv;
   logic                             wc_ff, nxt_wc;
   logic [afesc_pkg::ADDR_W-1:0]     wa_ff, nxt_wa;
   logic [afesc_pkg::DATA_W-1:0]     wd_ff, nxt_wd;

   // Load high aborts any partial group, so a short tail is dropped
   always_comb begin
      logic [afesc_pkg::DATA_W-1:0] shifted;
      shifted   = {sdat, data_ff[afesc_pkg::DATA_W-1:1]};
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_addr  = addr_ff;
      nxt_data  = data_ff;
      nxt_wv    = 1'b0;
      nxt_wc    = 1'b0;
      nxt_wa    = wa_ff;
      nxt_wd    = wd_ff;
      if (load_lvl) begin
         nxt_state = afesc_pkg::RX_ADDR;
         nxt_cnt   = '0;
         if (load_rise && state_ff == afesc_pkg::RX_HOLD) begin
            nxt_wv = 1'b1;
            nxt_wa = addr_ff;
            nxt_wd = data_ff;
         end
      end else if (sclk_rise) begin
         case (state_ff)
            afesc_pkg::RX_ADDR: begin
               nxt_addr = {sdat, addr_ff[afesc_pkg::ADDR_W-1:1]};
               nxt_cnt  = cnt_ff + 4'h1;
               if (cnt_ff == afesc_pkg::ADDR_LAST) begin
                  nxt_state = afesc_pkg::RX_DATA;
                  nxt_cnt   = '0;
               end
            end
            afesc_pkg::RX_DATA: begin
               nxt_data = shifted;
               nxt_cnt  = cnt_ff + 4'h1;
               if (cnt_ff == afesc_pkg::DATA_LAST) begin
                  nxt_state = afesc_pkg::RX_HOLD;
                  nxt_cnt   = '0;
               end
            end
            afesc_pkg::RX_HOLD: begin
               // A 17th bit means continuous mode: commit first word
               nxt_wv    = 1'b1;
               nxt_wa    = addr_ff;
               nxt_wd    = data_ff;
               nxt_addr  = addr_ff + 10'h001;
               nxt_data  = shifted;
               nxt_cnt   = 4'h1;
               nxt_state = afesc_pkg::RX_CONT;
            end
            afesc_pkg::RX_CONT: begin
               nxt_data = shifted;
               nxt_cnt  = cnt_ff + 4'h1;
               if (cnt_ff == afesc_pkg::DATA_LAST) begin
                  nxt_wv   = 1'b1;
                  nxt_wc   = 1'b1;
                  nxt_wa   = addr_ff;
                  nxt_wd   = shifted;
                  nxt_addr = addr_ff + 10'h001;
                  nxt_cnt  = '0;
               end
            end
            default: nxt_state = afesc_pkg::RX_ADDR;
         endcase
      end
   end

   // Registered strobes keep word data glitch free
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_ff <= afesc_pkg::RX_ADDR;
         cnt_ff   <= '0;
         addr_ff  <= '0;
         data_ff  <= '0;
         wv_ff    <= 1'b0;
         wc_ff    <= 1'b0;
         wa_ff    <= '0;
         wd_ff    <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         addr_ff  <= nxt_addr;
         data_ff  <= nxt_data;
         wv_ff    <= nxt_wv;
         wc_ff    <= nxt_wc;
         wa_ff    <= nxt_wa;
         wd_ff    <= nxt_wd;
      end
   end

   assign wr.wr_valid = wv_ff;
   assign wr.wr_cont  = wc_ff;
   assign wr.wr_addr  = wa_ff;
   assign wr.wr_data  = wd_ff;

endmodule

// ---- dv/afesc_host_model.sv ----
// Host model driving the three-wire serial write port
`timescale 1ns/1ps
module afesc_host_model (
   output logic serial_clk,
   output logic serial_in,
   output logic serial_load_strobe
);
   // Link idles with clock still and load high
   initial begin
      serial_clk = 1'b0;
      serial_in = 1'b0;
      serial_load_strobe = 1'b1;
   end
   // One frame of n bits, LSB first, 80 ns per bit
   task automatic send(input logic [39:0] bits, input int n);
      #1.3 serial_load_strobe = 1'b0;
      for (int i = 0; i < n; i++) begin
         serial_in = bits[i];
         #20 serial_clk = 1'b1;
         #40 serial_clk = 1'b0;
         #20;
      end
      // Released line shows the inverse, never a stale bit
      serial_in = ~serial_in;
      #40 serial_load_strobe = 1'b1;
      #40;
   endtask
endmodule

// ---- dv/afe_serial_control_registers_test.sv ----
// Self-checking bench for the serial control register bank
`timescale 1ns/1ps
module afe_serial_control_registers_test;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic        update_strobe = 1'b0;
   logic        serial_clk, serial_in, serial_load_strobe;
   logic        update_buffered, dummy_clamp_pol_high;
   logic        black_clamp_pol_high, sample_pol_high, standby_all;
   logic        standby_aux1, standby_aux2, test_enable, data_out_hiz;
   logic [2:0]  data_delay_ns;
   logic [1:0]  level_delay_sel;
   logic [4:0]  clamp_code;
   logic [15:0] clamp_target;
   logic [5:0]  defect_reject_level, power_trim;
   logic [9:0]  digital_gain;
   logic [3:0]  analog_gain;
   logic [7:0]  aux1_code, aux2_code;
   int          mismatches = 0;
   int          checks = 0;
   int          cycles = 0;

   afesc_host_model u_host (.serial_clk, .serial_in, .serial_load_strobe);
   afesc_regs u_dut (.sys_clk, .srst, .serial_clk, .serial_in,
      .serial_load_strobe, .update_strobe, .update_buffered,
      .dummy_clamp_pol_high, .black_clamp_pol_high, .sample_pol_high,
      .standby_all, .standby_aux1, .standby_aux2, .test_enable,
      .data_delay_ns, .data_out_hiz, .level_delay_sel, .clamp_code,
      .clamp_target, .defect_reject_level, .digital_gain, .analog_gain,
      .power_trim, .aux1_code, .aux2_code);

   // 200 MHz system clock
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Hang guard, far above the few thousand cycles needed
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Frame tail plus two cycles covers sync, commit and clamp stage
   task automatic wr(input logic [9:0] a, input logic [5:0] d);
      @(posedge sys_clk);
      u_host.send({24'h00_0000, d, a}, 16);
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic strobe(input logic v);
      @(posedge sys_clk);
      update_strobe <= v;
      repeat (8) @(posedge sys_clk);
   endtask

   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check("aux stby", {standby_aux2, standby_aux1}, 16'h0003);
      check("standby", {test_enable, standby_all}, 16'h0000);
      check("pol", {sample_pol_high, black_clamp_pol_high,
            dummy_clamp_pol_high}, 16'h0000);
      check("clamp", clamp_target, 16'h0020);
      check("code", clamp_code, 16'h0008);
      check("gain", digital_gain, 16'h00c0);
      check("defect", defect_reject_level, 16'h003f);
      check("trim", {analog_gain, power_trim}, 16'h0000);
      check("out", {data_out_hiz, data_delay_ns, level_delay_sel},
            16'h0000);
      wr(10'h000, 6'h39);
      check("pol", {sample_pol_high, black_clamp_pol_high,
            dummy_clamp_pol_high}, 16'h0007);
      check("buffered", update_buffered, 16'h0000);
      wr(10'h001, 6'h09);
      check("standby", {test_enable, standby_aux2, standby_aux1,
            standby_all}, 16'h0009);
      // Every delay code, outputs tri-stated meanwhile
      for (int c = 0; c < 4; c++) begin
         wr(10'h002, 6'h10 | 6'(c));
         check("delay", data_delay_ns, 16'(c * 2));
         check("hiz", data_out_hiz, 16'h0001);
      end
      wr(10'h002, 6'h00);
      check("hiz", data_out_hiz, 16'h0000);
      // Only the permitted sample delay code 01 is ever sent
      wr(10'h003, 6'h01);
      check("sdelay", level_delay_sel, 16'h0001);
      wr(10'h004, 6'h00);
      check("clamp", clamp_target, 16'h0010);
      wr(10'h004, 6'h1f);
      check("clamp", clamp_target, 16'h004e);
      check("code", clamp_code, 16'h001f);
      // Stream of three groups and a partial one that must drop
      @(posedge sys_clk);
      u_host.send({9'h000, 3'h7, 6'h03, 6'h2a, 6'h15, 10'h00a}, 31);
      repeat (2) @(posedge sys_clk);
      check("aux1", aux1_code, 16'h0095);
      check("aux2", aux2_code, 16'h0003);
      // Five whole groups, defect level up to power trim
      @(posedge sys_clk);
      u_host.send({6'h2d, 6'h3b, 6'h3f, 6'h2a, 6'h11, 10'h005},
                  40);
      repeat (2) @(posedge sys_clk);
      check("defect", defect_reject_level, 16'h0011);
      check("dgain", digital_gain, 16'h03ea);
      check("again", analog_gain, 16'h000b);
      check("power", power_trim, 16'h002d);
      // Buffered mode, rising edge first
      wr(10'h000, 6'h02);
      check("buffered", update_buffered, 16'h0001);
      wr(10'h001, 6'h06);
      check("held", standby_all, 16'h0001);
      strobe(1'b1);
      check("applied", {standby_aux1, standby_all}, 16'h0002);
      wr(10'h000, 6'h24);
      strobe(1'b0);
      check("fall ignored", sample_pol_high, 16'h0000);
      strobe(1'b1);
      check("rise", sample_pol_high, 16'h0001);
      check("buffered", update_buffered, 16'h0001);
      // Falling edge selected with the update bit clear
      strobe(1'b0);
      wr(10'h001, 6'h01);
      strobe(1'b1);
      check("rise ignored", standby_all, 16'h0000);
      strobe(1'b0);
      check("fall", standby_all, 16'h0001);
      close_out();
   end
endmodule
